// ==== rtl/idma_core.sv ====
// Purpose: Data-memory access with two indirect windows, pointers and accumulator.
// Assumes: Datapath issues at most one memory access per cycle; reads combinational.
// Notes: General memory is flip-flops, bank count is a parameter.
//
// How it works
// RQ1 - Window accesses go to the location held in the paired pointer.
// RQ2 - First pair reaches only bank 0; second pair reaches any bank.
// RQ3 - Indirect read of a window returns zero; indirect window write does nothing.
// RQ4 - Each pointer is an 8-bit register living in data memory.
// RQ5 - Pointers are read, written and modified like any data register.
// RQ6 - Unused special-purpose locations read as zero.
// RQ7 - Accumulator takes the ALU result whenever acc_src is not IDMA_SRC_NONE, unless a store to the accumulator location in the same cycle wins.
// RQ8 - Register-to-register moves only pass through the accumulator.
// RQ9 - Pointer replaces the direct address in the same access cycle.
`timescale 1ns/10ps
`default_nettype none
module idma_core #(
   parameter int BANKS = 2
) (
   input wire logic clock, // System clock.
   input wire logic nrst, // Asynchronous reset, active low.
   input wire logic [idma_pkg::ADDR_W-1:0] mem_addr, // Direct operand address, bank in top bit.
   input wire logic mem_rd, // Read strobe for the operand.
   input wire logic mem_wr, // Write strobe for the operand.
   input wire logic wr_from_acc, // Write data is the accumulator, else ALU result.
   input wire logic wr_alu, // Write the ALU result back to the operand.
   input wire idma_pkg::idma_src_t acc_src, // Accumulator load source.
   input wire idma_pkg::idma_op_t alu_op, // ALU operation.
   input wire logic [idma_pkg::DATA_W-1:0] imm_data, // Immediate operand.
   output logic [idma_pkg::DATA_W-1:0] rd_data, // Operand read value.
   output logic [idma_pkg::ADDR_W-1:0] eff_addr, // Effective address after redirection.
   output logic [idma_pkg::DATA_W-1:0] acc_out, // Accumulator contents.
   output logic [idma_pkg::DATA_W-1:0] ptr0_out, // First pointer contents.
   output logic [idma_pkg::DATA_W-1:0] ptr1_out // Second pointer contents.
);
   import idma_pkg::*;
   localparam int GP_DEPTH = BANKS * (2 ** OFFS_W);
   // Window 0 is tied to bank 0, whatever bank the instruction names.
   localparam logic BANK_0 = 1'b0;

   logic [DATA_W-1:0] mem_pointer_0_reg, mem_pointer_0_next;
   logic [DATA_W-1:0] mem_pointer_1_reg, mem_pointer_1_next;
   logic [DATA_W-1:0] accumulator_reg, accumulator_next;
   logic [DATA_W-1:0] gp_mem_reg [GP_DEPTH];
   logic [DATA_W-1:0] gp_mem_next [GP_DEPTH];
   logic [DATA_W-1:0] alu_a, alu_res, wr_val;
   logic via_w0, via_w1, is_gp, self_window;
   logic [ADDR_W-1:0] addr_eff;

   // True when an offset names one of the two windows.
   function automatic logic is_window(input logic [OFFS_W-1:0] o);
      is_window = (o == LOC_WINDOW_0) || (o == LOC_WINDOW_1);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Address redirection.
   // RQ9 same-cycle substitution
   always_comb begin
      via_w0 = (mem_addr[OFFS_W-1:0] == LOC_WINDOW_0);
      via_w1 = (mem_addr[OFFS_W-1:0] == LOC_WINDOW_1);
      // RQ1 window redirect
      // RQ2 bank reach
      if (via_w0) begin
         addr_eff = {BANK_0, mem_pointer_0_reg};
      end else if (via_w1) begin
         addr_eff = {mem_addr[ADDR_W-1], mem_pointer_1_reg};
      end else begin
         addr_eff = mem_addr;
      end
      // A window pointing at a window lands on nothing real.
      self_window = (via_w0 || via_w1) && is_window(addr_eff[OFFS_W-1:0]);
      is_gp = (addr_eff[OFFS_W-1:0] >= GP_BASE) && (int'(addr_eff[ADDR_W-1]) < BANKS);
   end
   assign eff_addr = addr_eff;

   ////////////////////////////////////////////////////////////////////////
   // Read mux.
   // Reads are gated by the strobe, so an idle cycle shows zero rather than stale data.
   // Redirection is one level only; a pointer naming a window never chains to a second pointer.
   always_comb begin
      rd_data = ZERO_BYTE;
      if (mem_rd) begin
         // RQ3 window reads zero
         if (self_window || is_window(addr_eff[OFFS_W-1:0])) begin
            rd_data = ZERO_BYTE;
         // RQ4 pointer in memory
         end else if (addr_eff[OFFS_W-1:0] == LOC_PTR_0) begin
            rd_data = mem_pointer_0_reg;
         end else if (addr_eff[OFFS_W-1:0] == LOC_PTR_1) begin
            rd_data = mem_pointer_1_reg;
         end else if (addr_eff[OFFS_W-1:0] == LOC_ACC) begin
            rd_data = accumulator_reg;
         end else if (is_gp) begin
            rd_data = gp_mem_reg[addr_eff];
         end else begin
            // RQ6 unused reads zero
            rd_data = ZERO_BYTE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ALU; operand A is the immediate or the memory read value.
   always_comb begin
      alu_a = (acc_src == IDMA_SRC_IMM) ? imm_data : rd_data;
      case (alu_op)
         IDMA_OP_PASS: alu_res = alu_a;
         IDMA_OP_ADD: alu_res = accumulator_reg + alu_a;
         IDMA_OP_SUB: alu_res = accumulator_reg - alu_a;
         IDMA_OP_AND: alu_res = accumulator_reg & alu_a;
         IDMA_OP_OR: alu_res = accumulator_reg | alu_a;
         IDMA_OP_XOR: alu_res = accumulator_reg ^ alu_a;
         IDMA_OP_SHL: alu_res = {alu_a[DATA_W-2:0], 1'b0};
         IDMA_OP_SHR: alu_res = {1'b0, alu_a[DATA_W-1:1]};
         default: alu_res = alu_a;
      endcase
      // RQ8 moves via accumulator
      // Write data is only the accumulator or an ALU result, never another register.
      wr_val = wr_from_acc ? accumulator_reg : alu_res;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state for pointers, accumulator and memory.
   // A store to the accumulator location wins over a load in the same cycle, so the store is not lost.
   always_comb begin
      mem_pointer_0_next = mem_pointer_0_reg;
      mem_pointer_1_next = mem_pointer_1_reg;
      accumulator_next = accumulator_reg;
      gp_mem_next = gp_mem_reg;
      // RQ7 ALU into accumulator
      if (acc_src != IDMA_SRC_NONE) begin
         accumulator_next = alu_res;
      end
      // Direct or redirected write; a window location itself is never written.
      if (mem_wr || wr_alu) begin
         // RQ3 window write ignored
         if (self_window || is_window(addr_eff[OFFS_W-1:0])) begin
            accumulator_next = accumulator_next;
         // RQ5 pointers writable
         end else if (addr_eff[OFFS_W-1:0] == LOC_PTR_0) begin
            mem_pointer_0_next = wr_val;
         end else if (addr_eff[OFFS_W-1:0] == LOC_PTR_1) begin
            mem_pointer_1_next = wr_val;
         end else if (addr_eff[OFFS_W-1:0] == LOC_ACC) begin
            accumulator_next = wr_val;
         end else if (is_gp) begin
            gp_mem_next[addr_eff] = wr_val;
         end
      end
   end

   // Registers only; memory has no reset, pointers and accumulator do.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mem_pointer_0_reg <= PTR_RESET;
         mem_pointer_1_reg <= PTR_RESET;
         accumulator_reg <= ACC_RESET;
      end else begin
         mem_pointer_0_reg <= mem_pointer_0_next;
         mem_pointer_1_reg <= mem_pointer_1_next;
         accumulator_reg <= accumulator_next;
      end
   end

   always_ff @(posedge clock) begin
      gp_mem_reg <= gp_mem_next;
   end

   assign acc_out = accumulator_reg;
   assign ptr0_out = mem_pointer_0_reg;
   assign ptr1_out = mem_pointer_1_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_w0_redirect;
      @(posedge clock) disable iff (!nrst) (mem_addr[OFFS_W-1:0] == LOC_WINDOW_0) |-> (eff_addr == {BANK_0, ptr0_out});
   endproperty
   a_w0_redirect: assert property (p_w0_redirect) else $error("window 0 not redirected"); // RQ1
   property p_w1_bank;
      @(posedge clock) disable iff (!nrst)
         (mem_addr[OFFS_W-1:0] == LOC_WINDOW_1) |-> (eff_addr == {mem_addr[ADDR_W-1], ptr1_out});
   endproperty
   a_w1_bank: assert property (p_w1_bank) else $error("window 1 bank wrong"); // RQ2
   property p_win_zero;
      @(posedge clock) disable iff (!nrst) (mem_rd && is_window(eff_addr[OFFS_W-1:0])) |-> (rd_data == ZERO_BYTE);
   endproperty
   a_win_zero: assert property (p_win_zero) else $error("window read not zero"); // RQ3
   property p_ptr_write;
      @(posedge clock) disable iff (!nrst)
         ((mem_wr || wr_alu) && eff_addr[OFFS_W-1:0] == LOC_PTR_0) |=> (ptr0_out == $past(wr_val));
   endproperty
   a_ptr_write: assert property (p_ptr_write) else $error("pointer 0 not written"); // RQ5
   property p_ptr_hold;
      @(posedge clock) disable iff (!nrst)
         !((mem_wr || wr_alu) && eff_addr[OFFS_W-1:0] == LOC_PTR_1) |=> $stable(ptr1_out);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer 1 changed"); // RQ4
   property p_unused_zero;
      @(posedge clock) disable iff (!nrst)
         (mem_rd && eff_addr[OFFS_W-1:0] < GP_BASE && !is_window(eff_addr[OFFS_W-1:0])
            && eff_addr[OFFS_W-1:0] != LOC_PTR_0 && eff_addr[OFFS_W-1:0] != LOC_PTR_1
            && eff_addr[OFFS_W-1:0] != LOC_ACC) |-> (rd_data == ZERO_BYTE);
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused not zero"); // RQ6
   property p_acc_alu;
      @(posedge clock) disable iff (!nrst)
         (acc_src != IDMA_SRC_NONE && !(mem_wr || wr_alu)) |=> (acc_out == $past(alu_res));
   endproperty
   a_acc_alu: assert property (p_acc_alu) else $error("accumulator missed result"); // RQ7
   property p_no_direct;
      @(posedge clock) disable iff (!nrst) (mem_wr && wr_from_acc && is_gp) |=> (gp_mem_reg[$past(eff_addr)] == $past(acc_out));
   endproperty
   a_no_direct: assert property (p_no_direct) else $error("write not from accumulator"); // RQ8
   property p_same_cycle;
      @(posedge clock) disable iff (!nrst) (mem_rd && via_w0 && ptr0_out == LOC_PTR_1) |-> (rd_data == ptr1_out);
   endproperty
   a_same_cycle: assert property (p_same_cycle) else $error("redirect not same cycle"); // RQ9
   // Main scenarios: window store, bank-1 window read, pointer increment, window aimed at a window.
   c_w0_write: cover property (@(posedge clock) disable iff (!nrst) mem_wr && via_w0 && is_gp);
   c_self_read: cover property (@(posedge clock) disable iff (!nrst) mem_rd && self_window);
   c_w1_bank1: cover property (@(posedge clock) disable iff (!nrst) mem_rd && via_w1 && eff_addr[ADDR_W-1]);
   c_ptr_inc: cover property (@(posedge clock) disable iff (!nrst) wr_alu && eff_addr[OFFS_W-1:0] == LOC_PTR_0);
endmodule
`default_nettype wire

// ==== rtl/idma_pkg.sv ====
// Purpose: Shared constants for the indirect data-memory access block.
// Assumes: 8-bit data, 9-bit data-memory address (bank bit plus 8-bit offset).
// Notes: Special-purpose locations sit at the bottom of every bank.
package idma_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 9;
   localparam int OFFS_W = 8;
   // Special-purpose area locations within a bank.
   localparam logic [7:0] LOC_WINDOW_0 = 8'h00;
   localparam logic [7:0] LOC_PTR_0 = 8'h01;
   localparam logic [7:0] LOC_WINDOW_1 = 8'h02;
   localparam logic [7:0] LOC_PTR_1 = 8'h03;
   localparam logic [7:0] LOC_ACC = 8'h05;
   // First general-purpose location; below it only the listed locations exist.
   localparam logic [7:0] GP_BASE = 8'h60;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] PTR_RESET = 8'h00;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   // ALU operations the datapath may request.
   typedef enum logic [2:0] {
      IDMA_OP_PASS,
      IDMA_OP_ADD,
      IDMA_OP_SUB,
      IDMA_OP_AND,
      IDMA_OP_OR,
      IDMA_OP_XOR,
      IDMA_OP_SHL,
      IDMA_OP_SHR
   } idma_op_t;
   // Where an accumulator load takes its operand from.
   typedef enum logic [1:0] {
      IDMA_SRC_NONE,
      IDMA_SRC_IMM,
      IDMA_SRC_MEM
   } idma_src_t;
endpackage

// ==== tb/idma_dp_model.sv ====
// Purpose: Datapath model that issues one operand access per clock.
// Assumes: Requests change by non-blocking assignment at the rising edge.
// Notes: A request stands one cycle; the next call replaces it.
`timescale 1ns/10ps
`default_nettype none
module idma_dp_model (
   input wire logic clock, // System clock.
   output logic [idma_pkg::ADDR_W-1:0] mem_addr, // Operand address.
   output logic mem_rd, // Read strobe.
   output logic mem_wr, // Write strobe.
   output logic wr_from_acc, // Write data select.
   output logic wr_alu, // ALU write-back.
   output var idma_pkg::idma_src_t acc_src, // Accumulator source.
   output var idma_pkg::idma_op_t alu_op, // ALU operation.
   output logic [idma_pkg::DATA_W-1:0] imm_data // Immediate operand.
);
   import idma_pkg::*;
   // Idle request from time zero so no input floats during reset.
   initial begin
      mem_addr = 9'h000;
      {mem_rd, mem_wr, wr_from_acc, wr_alu} = 4'h0;
      acc_src = IDMA_SRC_NONE;
      alu_op = IDMA_OP_PASS;
      imm_data = 8'h00;
   end
   // Flags are rd, wr, from_acc, alu; returns once the edge has settled.
   task automatic issue(input logic [8:0] a, input logic [3:0] f, input idma_src_t s, input idma_op_t o,
                        input logic [7:0] d);
      @(posedge clock);
      mem_addr <= a;
      {mem_rd, mem_wr, wr_from_acc, wr_alu} <= f;
      acc_src <= s;
      alu_op <= o;
      imm_data <= d;
      #1;
   endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the indirect data-memory access block.
// Assumes: One access per cycle, registers read one edge after the request, read data and effective address in its own cycle.
// Notes: Memory is not reset, so only written locations are compared.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import idma_pkg::*;
   logic clock, nrst;
   logic [8:0] mem_addr, eff_addr;
   logic mem_rd, mem_wr, wr_from_acc, wr_alu;
   idma_src_t acc_src;
   idma_op_t alu_op;
   logic [7:0] imm_data, rd_data, acc_out, ptr0_out, ptr1_out, exp;
   int errors = 0;
   int samples_checked = 0;
   idma_dp_model i_idma_dp_model (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .wr_from_acc(wr_from_acc), .wr_alu(wr_alu), .acc_src(acc_src), .alu_op(alu_op), .imm_data(imm_data));
   idma_core i_idma_core (.clock(clock), .nrst(nrst), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .wr_from_acc(wr_from_acc), .wr_alu(wr_alu), .acc_src(acc_src), .alu_op(alu_op), .imm_data(imm_data),
      .rd_data(rd_data), .eff_addr(eff_addr), .acc_out(acc_out), .ptr0_out(ptr0_out), .ptr1_out(ptr1_out));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Compare and count; a mismatch prints at once.
   task automatic chk(input logic [8:0] seen, input logic [8:0] want, input string m);
      samples_checked++;
      if (seen !== want) begin
         errors++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic ld(input logic [7:0] v);
      i_idma_dp_model.issue(9'h000, 4'h0, IDMA_SRC_IMM, IDMA_OP_PASS, v);
   endtask
   task automatic wa(input logic [8:0] a);
      i_idma_dp_model.issue(a, 4'h6, IDMA_SRC_NONE, IDMA_OP_PASS, 8'h00);
   endtask
   task automatic rd(input logic [8:0] a);
      i_idma_dp_model.issue(a, 4'h8, IDMA_SRC_NONE, IDMA_OP_PASS, 8'h00);
   endtask
   // Reference ALU, sub is accumulator minus operand.
   function automatic logic [7:0] alu(input idma_op_t o, input logic [7:0] c, input logic [7:0] a);
      case (o)
         IDMA_OP_ADD: return c + a;
         IDMA_OP_SUB: return c - a;
         IDMA_OP_AND: return c & a;
         IDMA_OP_OR: return c | a;
         IDMA_OP_XOR: return c ^ a;
         IDMA_OP_SHL: return a << 1;
         IDMA_OP_SHR: return a >> 1;
         default: return a;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_windows();
      ld(8'h61); wa(9'h001); rd(9'h061);
      chk(ptr0_out, 9'h061, "ptr0 load");
      ld(8'hA5); wa(9'h000);
      chk(eff_addr, 9'h061, "window0 redirect");
      rd(9'h061);
      chk(rd_data, 9'h0A5, "window0 write target");
      rd(9'h100);
      chk(eff_addr, 9'h061, "window0 bank forced");
      chk(rd_data, 9'h0A5, "window0 read");
      ld(8'h70); wa(9'h003); ld(8'h3C); wa(9'h102);
      chk(eff_addr, 9'h170, "window1 any bank");
      rd(9'h170);
      chk(rd_data, 9'h03C, "window1 write target");
      rd(9'h102);
      chk(rd_data, 9'h03C, "window1 read bank 1");
      $display("test windows done");
   endtask
   task automatic t_zero();
      logic [8:0] un[4] = '{9'h004, 9'h006, 9'h05F, 9'h104};
      ld(8'hFF);
      foreach (un[i]) begin
         wa(un[i]); rd(un[i]);
         chk(rd_data, 9'h000, "unused location");
      end
      ld(8'h02); wa(9'h001); rd(9'h000);
      chk(rd_data, 9'h000, "window read of window");
      $display("test zero reads done");
   endtask
   task automatic t_alu();
      for (int o = 0; o < 8; o++) begin
         ld(8'hC3);
         i_idma_dp_model.issue(9'h000, 4'h0, IDMA_SRC_IMM, idma_op_t'(o), 8'h35);
         exp = alu(idma_op_t'(o), 8'hC3, 8'h35);
         rd(9'h061);
         chk(acc_out, exp, "alu result");
      end
      $display("test alu done");
   endtask
   task automatic t_incr();
      ld(8'h61); wa(9'h001); ld(8'h01);
      i_idma_dp_model.issue(9'h001, 4'h9, IDMA_SRC_NONE, IDMA_OP_ADD, 8'h00);
      i_idma_dp_model.issue(9'h001, 4'h8, IDMA_SRC_MEM, IDMA_OP_PASS, 8'h00);
      chk(ptr0_out, 9'h062, "ptr0 increment");
      wa(9'h003); rd(9'h061);
      chk(ptr1_out, 9'h062, "move through accumulator");
      ld(8'h03); wa(9'h001); rd(9'h000);
      chk(rd_data, 9'h062, "pointer read through window");
      $display("test increment done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Tests take under a hundred cycles; the limit allows ample margin.
   initial begin
      #50000;
      errors++;
      wrap_up();
   end
   initial begin
      nrst = 1'b0;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      #1;
      chk(acc_out, 9'h000, "acc reset");
      chk(ptr0_out, 9'h000, "ptr0 reset");
      chk(ptr1_out, 9'h000, "ptr1 reset");
      t_windows();
      t_zero();
      t_alu();
      t_incr();
      wrap_up();
   end
endmodule
`default_nettype wire
